// [common/dwell_if.sv]
// Handshake between the scan sequencer and its dwell timer
`timescale 1ns/1ps
`default_nettype none
interface dwell_if;
   import scan_pkg::*;
   logic start;
   logic stop;
   logic [INTV_W-1:0] interval_ms;
   logic done;
   logic busy;

   modport ctrl (output start, output stop, output interval_ms,
                 input done, input busy);
   modport timer (input start, input stop, input interval_ms,
                  output done, output busy);
endinterface
`default_nettype wire

// [common/scan_pkg.sv]
// Constants, types and helpers shared by the relay scan sequencer
//
// Behaviour
// - Digits then first-channel key store the scan start channel.
// - Digits then last-channel key store the scan end channel.
// - A channel not installed raises the error lamp and is not stored.
// - Program key, 6, pole choice 1/2/4, enter sets poles per channel.
// - Interval key, digits, enter set dwell 0.010 to 999.999 seconds.
// - Single/continuous keys pick those modes; channel key picks step mode.
// - In step mode each run press scans exactly one channel.
// - Step: lamp on at close; after dwell open, lamp off, advance.
// - Step: after the end channel, current channel returns to start.
// - Reset key halts any scan and sets current channel to start.
// - Single mode: one run press scans current channel to end in order.
// - Single scan end: return to start, stop, run lamp off.
// - Single and continuous modes each light their own lamp.
// - Single/continuous: run press mid-scan halts with channel closed; next press resumes.
// - Continuous mode wraps end to start until run is pressed.
// - Channel key then reset lights channel lamp, current to start.
// - Scan start closes the current channel and lights run lamp together.
package scan_pkg;

   // Widths
   localparam int CHAN_W = 7;
   localparam int INTV_W = 20;
   localparam int KEY_W = 5;
   localparam int TICK_W = 16;

   // Key codes from the keypad scanner
   localparam logic [KEY_W-1:0] KEY_DIGIT_MAX = 5'h09;
   localparam logic [KEY_W-1:0] KEY_FIRST = 5'h0A;
   localparam logic [KEY_W-1:0] KEY_LAST = 5'h0B;
   localparam logic [KEY_W-1:0] KEY_PROGRAM = 5'h0C;
   localparam logic [KEY_W-1:0] KEY_INTERVAL = 5'h0D;
   localparam logic [KEY_W-1:0] KEY_ENTER = 5'h0E;
   localparam logic [KEY_W-1:0] KEY_SINGLE = 5'h0F;
   localparam logic [KEY_W-1:0] KEY_CONT = 5'h10;
   localparam logic [KEY_W-1:0] KEY_RUN = 5'h11;
   localparam logic [KEY_W-1:0] KEY_CHANNEL = 5'h12;
   localparam logic [KEY_W-1:0] KEY_RESET = 5'h13;

   // Program number and pole widths
   localparam logic [3:0] PROG_POLES = 4'h6;
   localparam logic [2:0] POLES_1 = 3'h1;
   localparam logic [2:0] POLES_2 = 3'h2;
   localparam logic [2:0] POLES_4 = 3'h4;
   localparam logic [2:0] POLES_RST = 3'h1;

   // Reset values and limits
   localparam logic [CHAN_W-1:0] CHAN_RST = 7'h01;
   localparam logic [INTV_W-1:0] INTV_MIN_MS = 20'h0_000A;
   localparam logic [INTV_W-1:0] INTV_RST_MS = 20'h0_03E8;
   localparam logic [2:0] INTV_DIGITS = 3'h6;

   // Timing: 1 ms tick at the 40 MHz clock
   localparam int CLK_PERIOD_NS = 25;
   localparam int TICK_TIME_NS = 1000000;
   localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0]
   {
      MODE_STEP = 2'b00,
      MODE_SINGLE = 2'b01,
      MODE_CONT = 2'b10
   } scan_mode_t;

   typedef enum logic [2:0]
   {
      ENT_CHAN = 3'b000,
      ENT_PROG = 3'b001,
      ENT_POLES = 3'b010,
      ENT_POLE_OK = 3'b011,
      ENT_INTV = 3'b100
   } entry_t;

   typedef enum logic [1:0]
   {
      SC_IDLE = 2'b00,
      SC_DWELL = 2'b01,
      SC_NEXT = 2'b10,
      SC_HALT = 2'b11
   } scan_t;

   // Two BCD digits to a channel number
   function automatic logic [CHAN_W-1:0] bcd2bin(input logic [3:0] tens,
                                                 input logic [3:0] ones);
      // Widen before the product so tens of 2..9 do not wrap in 4 bits
      bcd2bin = CHAN_W'(CHAN_W'(tens) * CHAN_W'(4'd10) + CHAN_W'(ones));
   endfunction

   // Advance with wrap back to the start channel
   function automatic logic [CHAN_W-1:0] next_chan(
      input logic [CHAN_W-1:0] cur,
      input logic [CHAN_W-1:0] last,
      input logic [CHAN_W-1:0] first);
      next_chan = (cur >= last) ? first : CHAN_W'(cur + 1'b1);
   endfunction

endpackage

// [hdl/dwell_timer.sv]
// Dwell interval timer counting 1 ms ticks
`timescale 1ns/1ps
`default_nettype none
module dwell_timer
   import scan_pkg::*;
#(
   parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control from the sequencer
   dwell_if.timer t
);

   logic [TICK_W-1:0] tick_q;
   logic [INTV_W-1:0] cnt_q;
   logic busy_q;
   logic done_q;
   wire tick_wrap = (tick_q == TICK_W'(TICK_CYCLES_P - 1));
   wire last_ms = (cnt_q == INTV_W'(1));

   // Start reloads both counters so every dwell is a whole count of ms
   always_ff @(posedge clk)
   begin
      if (rst || t.stop)
      begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         tick_q <= '0;
         cnt_q <= '0;
      end
      else if (t.start)
      begin
         busy_q <= 1'b1;
         done_q <= 1'b0;
         tick_q <= '0;
         cnt_q <= t.interval_ms;
      end
      else
      begin
         done_q <= busy_q && tick_wrap && last_ms;
         busy_q <= busy_q && !(tick_wrap && last_ms);
         tick_q <= (busy_q && !tick_wrap) ? TICK_W'(tick_q + 1'b1) : '0;
         cnt_q <= (busy_q && tick_wrap) ? INTV_W'(cnt_q - 1'b1) : cnt_q;
      end
   end

   assign t.done = done_q;
   assign t.busy = busy_q;

   property p_dwell_end;
      @(posedge clk) disable iff (rst)
      busy_q && tick_wrap && last_ms && !t.stop && !t.start
      |=> done_q && !busy_q ##1 !done_q;
   endproperty
   a_dwell_end: assert property (p_dwell_end)
      else $error("dwell did not end on last tick");

endmodule
`default_nettype wire

// [hdl/relay_channel_scan_sequencer.sv]
// Keypad-driven relay channel scan sequencer
`timescale 1ns/1ps
`default_nettype none
module relay_channel_scan_sequencer
   import scan_pkg::*;
#(
   parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Keypad, asynchronous to clk
   input wire logic key_strobe,
   input wire logic [KEY_W-1:0] key_code,
   // Installed card configuration
   input wire logic [CHAN_W-1:0] installed_chans,
   // Relay card drivers
   output logic [CHAN_W-1:0] relay_chan_q,
   output logic relay_close_q,
   output logic [2:0] pole_width_q,
   // Display and lamps
   output logic [CHAN_W-1:0] cur_chan_q,
   output logic run_lamp_q,
   output logic single_lamp_q,
   output logic cont_lamp_q,
   output logic chan_lamp_q,
   output logic error_lamp_q
);

   dwell_if dw ();

   dwell_timer #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_timer
   (
      .clk(clk),
      .rst(rst),
      .t(dw.timer)
   );

   // Synchronisers; the code must be steady while the strobe is high
   logic strobe_meta_q, strobe_q, strobe_prev_q;
   logic [KEY_W-1:0] code_meta_q, code_q;
   logic [CHAN_W-1:0] inst_meta_q, inst_q;
   always_ff @(posedge clk)
   begin
      strobe_meta_q <= key_strobe;
      strobe_q <= strobe_meta_q;
      strobe_prev_q <= rst ? 1'b0 : strobe_q;
      code_meta_q <= key_code;
      code_q <= code_meta_q;
      inst_meta_q <= installed_chans;
      inst_q <= inst_meta_q;
   end

   // Key decode
   wire press = strobe_q && !strobe_prev_q;
   wire is_digit = press && (code_q <= KEY_DIGIT_MAX);
   wire [3:0] digit = code_q[3:0];
   wire k_first = press && (code_q == KEY_FIRST);
   wire k_last = press && (code_q == KEY_LAST);
   wire k_prog = press && (code_q == KEY_PROGRAM);
   wire k_intv = press && (code_q == KEY_INTERVAL);
   wire k_enter = press && (code_q == KEY_ENTER);
   wire k_single = press && (code_q == KEY_SINGLE);
   wire k_cont = press && (code_q == KEY_CONT);
   wire k_run = press && (code_q == KEY_RUN);
   wire k_chan = press && (code_q == KEY_CHANNEL);
   wire k_reset = press && (code_q == KEY_RESET);

   // Entry state
   entry_t ent_q, ent_d;
   scan_mode_t mode_q, mode_d;
   logic [3:0] tens_q, tens_d, ones_q, ones_d;
   logic [CHAN_W-1:0] start_q, start_d, end_q, end_d;
   logic [2:0] pend_q, pend_d, poles_d;
   logic [INTV_W-1:0] acc_q, acc_d, intv_q, intv_d;
   logic [2:0] ndig_q, ndig_d;
   logic err_d, chan_lamp_d;

   // Entered channel and its check against the installed cards
   wire [CHAN_W-1:0] entered = bcd2bin(tens_q, ones_q);
   wire chan_ok = (entered != '0) && (entered <= inst_q);
   wire pole_ok = (digit == 4'(POLES_1)) || (digit == 4'(POLES_2)) ||
                  (digit == 4'(POLES_4));
   wire [INTV_W-1:0] acc_next = INTV_W'(acc_q * 4'd10) + INTV_W'(digit);

   // Keypad entry decoding; any key clears a standing error
   always_comb
   begin
      ent_d = ent_q;
      mode_d = mode_q;
      tens_d = tens_q;
      ones_d = ones_q;
      start_d = start_q;
      end_d = end_q;
      pend_d = pend_q;
      poles_d = pole_width_q;
      acc_d = acc_q;
      intv_d = intv_q;
      ndig_d = ndig_q;
      err_d = press ? 1'b0 : error_lamp_q;
      chan_lamp_d = chan_lamp_q;
      if (is_digit)
      begin
         case (ent_q)
            ENT_CHAN:
            begin
               tens_d = ones_q;
               ones_d = digit;
            end
            ENT_PROG:
            begin
               ent_d = (digit == PROG_POLES) ? ENT_POLES : ENT_CHAN;
               err_d = (digit != PROG_POLES);
            end
            ENT_POLES, ENT_POLE_OK:
            begin
               pend_d = pole_ok ? digit[2:0] : pend_q;
               ent_d = pole_ok ? ENT_POLE_OK : ent_q;
               err_d = !pole_ok;
            end
            ENT_INTV:
            begin
               // Six digits fill 000.000; further digits are ignored
               if (ndig_q < INTV_DIGITS)
               begin
                  acc_d = acc_next;
                  ndig_d = 3'(ndig_q + 1'b1);
               end
            end
            default:
               ent_d = ENT_CHAN;
         endcase
      end
      else if (k_first && ent_q == ENT_CHAN)
      begin
         start_d = chan_ok ? entered : start_q;
         err_d = !chan_ok;
      end
      else if (k_last && ent_q == ENT_CHAN)
      begin
         end_d = chan_ok ? entered : end_q;
         err_d = !chan_ok;
      end
      else if (k_prog)
         ent_d = ENT_PROG;
      else if (k_intv)
      begin
         ent_d = ENT_INTV;
         acc_d = '0;
         ndig_d = '0;
         chan_lamp_d = 1'b0;
      end
      else if (k_enter)
      begin
         if (ent_q == ENT_POLE_OK)
            poles_d = pend_q;
         if (ent_q == ENT_INTV && acc_q >= INTV_MIN_MS)
            intv_d = acc_q;
         err_d = (ent_q == ENT_INTV) && (acc_q < INTV_MIN_MS);
         ent_d = ENT_CHAN;
      end
      else if (k_chan)
      begin
         mode_d = MODE_STEP;
         chan_lamp_d = 1'b1;
         ent_d = ENT_CHAN;
      end
      else if (k_single)
         mode_d = MODE_SINGLE;
      else if (k_cont)
         mode_d = MODE_CONT;
   end

   // Entry registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ent_q <= ENT_CHAN;
         mode_q <= MODE_STEP;
         tens_q <= '0;
         ones_q <= '0;
         start_q <= CHAN_RST;
         end_q <= CHAN_RST;
         pend_q <= POLES_RST;
         pole_width_q <= POLES_RST;
         acc_q <= '0;
         intv_q <= INTV_RST_MS;
         ndig_q <= '0;
         error_lamp_q <= 1'b0;
         chan_lamp_q <= 1'b0;
         single_lamp_q <= 1'b0;
         cont_lamp_q <= 1'b0;
      end
      else
      begin
         ent_q <= ent_d;
         mode_q <= mode_d;
         tens_q <= tens_d;
         ones_q <= ones_d;
         start_q <= start_d;
         end_q <= end_d;
         pend_q <= pend_d;
         pole_width_q <= poles_d;
         acc_q <= acc_d;
         intv_q <= intv_d;
         ndig_q <= ndig_d;
         error_lamp_q <= err_d;
         chan_lamp_q <= chan_lamp_d;
         single_lamp_q <= (mode_d == MODE_SINGLE);
         cont_lamp_q <= (mode_d == MODE_CONT);
      end
   end

   // Scan sequencing
   scan_t scan_q, scan_d;
   logic [CHAN_W-1:0] cur_d, relay_chan_d;
   logic close_d, run_lamp_d, t_start, t_stop;
   wire at_end = (cur_chan_q >= end_q);
   wire [CHAN_W-1:0] adv = next_chan(cur_chan_q, end_q, start_q);

   // Relay number only moves while the relay is open, so two never close
   always_comb
   begin
      scan_d = scan_q;
      cur_d = cur_chan_q;
      relay_chan_d = relay_chan_q;
      close_d = relay_close_q;
      run_lamp_d = run_lamp_q;
      t_start = 1'b0;
      t_stop = 1'b0;
      if (k_reset)
      begin
         scan_d = SC_IDLE;
         cur_d = start_q;
         close_d = 1'b0;
         run_lamp_d = 1'b0;
         t_stop = 1'b1;
      end
      else
      begin
         case (scan_q)
            SC_IDLE:
               if (k_run)
               begin
                  relay_chan_d = cur_chan_q;
                  close_d = 1'b1;
                  run_lamp_d = 1'b1;
                  t_start = 1'b1;
                  scan_d = SC_DWELL;
               end
            SC_DWELL:
               if (k_run && mode_q != MODE_STEP)
               begin
                  // Channel stays closed while halted
                  t_stop = 1'b1;
                  run_lamp_d = 1'b0;
                  scan_d = SC_HALT;
               end
               else if (dw.done)
               begin
                  close_d = 1'b0;
                  case (mode_q)
                     MODE_SINGLE:
                     begin
                        cur_d = at_end ? start_q : adv;
                        run_lamp_d = !at_end;
                        scan_d = at_end ? SC_IDLE : SC_NEXT;
                     end
                     MODE_CONT:
                     begin
                        cur_d = adv;
                        scan_d = SC_NEXT;
                     end
                     default:
                     begin
                        cur_d = adv;
                        run_lamp_d = 1'b0;
                        scan_d = SC_IDLE;
                     end
                  endcase
               end
            SC_NEXT:
            begin
               relay_chan_d = cur_chan_q;
               close_d = 1'b1;
               t_start = 1'b1;
               scan_d = SC_DWELL;
            end
            SC_HALT:
               if (k_run)
               begin
                  run_lamp_d = 1'b1;
                  t_start = 1'b1;
                  scan_d = SC_DWELL;
               end
            default:
               scan_d = SC_IDLE;
         endcase
      end
   end

   // Scan registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         scan_q <= SC_IDLE;
         cur_chan_q <= CHAN_RST;
         relay_chan_q <= CHAN_RST;
         relay_close_q <= 1'b0;
         run_lamp_q <= 1'b0;
      end
      else
      begin
         scan_q <= scan_d;
         cur_chan_q <= cur_d;
         relay_chan_q <= relay_chan_d;
         relay_close_q <= close_d;
         run_lamp_q <= run_lamp_d;
      end
   end

   // Timer control
   assign dw.start = t_start;
   assign dw.stop = t_stop;
   assign dw.interval_ms = intv_q;

   sequence s_run_from_idle;
      scan_q == SC_IDLE && k_run && !rst;
   endsequence
   sequence s_closed_lit;
      relay_close_q && run_lamp_q && scan_q == SC_DWELL;
   endsequence

   property p_start_close;
      @(posedge clk) disable iff (rst)
      s_run_from_idle |=> s_closed_lit ##0
         (relay_chan_q == $past(cur_chan_q));
   endproperty
   a_start_close: assert property (p_start_close)
      else $error("scan start did not close channel with lamp");

   property p_break_first;
      @(posedge clk) disable iff (rst)
      $changed(relay_chan_q) |-> !$past(relay_close_q);
   endproperty
   a_break_first: assert property (p_break_first)
      else $error("relay number moved while closed");

   property p_first_store;
      @(posedge clk) disable iff (rst)
      k_first && ent_q == ENT_CHAN && chan_ok
      |=> start_q == $past(entered) && !error_lamp_q;
   endproperty
   a_first_store: assert property (p_first_store)
      else $error("start channel not stored");

   property p_last_store;
      @(posedge clk) disable iff (rst)
      k_last && ent_q == ENT_CHAN && chan_ok |=> end_q == $past(entered);
   endproperty
   a_last_store: assert property (p_last_store)
      else $error("end channel not stored");

   property p_bad_chan;
      @(posedge clk) disable iff (rst)
      (k_first || k_last) && ent_q == ENT_CHAN && !chan_ok
      |=> error_lamp_q && $stable(start_q) && $stable(end_q);
   endproperty
   a_bad_chan: assert property (p_bad_chan)
      else $error("missing channel accepted");

   property p_reset_key;
      @(posedge clk) disable iff (rst)
      k_reset |=> cur_chan_q == $past(start_q) && !relay_close_q &&
         !run_lamp_q && scan_q == SC_IDLE;
   endproperty
   a_reset_key: assert property (p_reset_key)
      else $error("reset key did not return to start");

   property p_halt;
      @(posedge clk) disable iff (rst)
      scan_q == SC_DWELL && k_run && mode_q != MODE_STEP
      |=> scan_q == SC_HALT && relay_close_q && !run_lamp_q;
   endproperty
   a_halt: assert property (p_halt)
      else $error("halt did not keep channel closed");

   property p_step_wrap;
      @(posedge clk) disable iff (rst)
      scan_q == SC_DWELL && dw.done && mode_q == MODE_STEP && at_end &&
         !k_reset && !k_run
      |=> cur_chan_q == $past(start_q) && !run_lamp_q && !relay_close_q;
   endproperty
   a_step_wrap: assert property (p_step_wrap)
      else $error("step mode did not wrap to start");

   property p_mode_lamp;
      @(posedge clk) disable iff (rst)
      k_single |=> single_lamp_q && !cont_lamp_q ##1
         (single_lamp_q || $past(k_cont || k_chan));
   endproperty
   a_mode_lamp: assert property (p_mode_lamp)
      else $error("single lamp not lit");

   property p_pole_set;
      @(posedge clk) disable iff (rst)
      k_enter && ent_q == ENT_POLE_OK |=> pole_width_q == $past(pend_q);
   endproperty
   a_pole_set: assert property (p_pole_set)
      else $error("pole width not set");

   property p_intv_set;
      @(posedge clk) disable iff (rst)
      k_enter && ent_q == ENT_INTV && acc_q >= INTV_MIN_MS
      |=> intv_q == $past(acc_q);
   endproperty
   a_intv_set: assert property (p_intv_set)
      else $error("interval not stored");

endmodule
`default_nettype wire

// [verification/scan_partner.sv]
// Keypad and relay card model for the scan sequencer bench
`timescale 1ns/1ps
`default_nettype none
module scan_partner
   import scan_pkg::*;
(
   // Clock
   input wire logic clk,
   // Keypad side
   output logic key_strobe,
   output logic [KEY_W-1:0] key_code,
   // Relay card side
   input wire logic [CHAN_W-1:0] relay_chan_q,
   input wire logic relay_close_q
);
   logic [CHAN_W-1:0] closed_q[$];
   logic [CHAN_W-1:0] prev_chan;
   logic prev_close = 1'b0;
   int violations = 0;

   initial
   begin
      key_strobe = 1'b0;
      key_code = 5'h1F;
   end

   // Hold the code past the sync delay, then idle with the inverted code
   task automatic press(input logic [KEY_W-1:0] c);
      @(posedge clk);
      key_code <= c;
      key_strobe <= 1'b1;
      repeat (4) @(posedge clk);
      key_strobe <= 1'b0;
      key_code <= ~c;
      repeat (5) @(posedge clk);
   endtask

   // Log each closure; a channel must not change while closed
   always @(posedge clk)
   begin
      prev_close <= relay_close_q;
      prev_chan <= relay_chan_q;
      if (relay_close_q && !prev_close)
         closed_q.push_back(relay_chan_q);
      if (relay_close_q && prev_close && relay_chan_q !== prev_chan)
         violations++;
   end
endmodule
`default_nettype wire

// [verification/tb_relay_channel_scan_sequencer.sv]
// Self-checking bench for the relay channel scan sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_relay_channel_scan_sequencer;
   import scan_pkg::*;
   localparam int TICKS = 4;
   localparam int DWELL = 10 * TICKS;
   logic clk = 1'b0;
   logic rst = 1'b1;
   wire logic key_strobe;
   wire logic [KEY_W-1:0] key_code;
   logic [CHAN_W-1:0] installed_chans = 7'h14;
   logic [CHAN_W-1:0] relay_chan_q, cur_chan_q;
   logic relay_close_q, run_lamp_q, single_lamp_q, cont_lamp_q;
   logic chan_lamp_q, error_lamp_q;
   logic [2:0] pole_width_q;
   int num_errors = 0;
   int checked = 0;
   int run_len = 0;
   int last_len = 0;
   logic [2:0] pw [3] = '{POLES_4, POLES_1, POLES_2};

   always #12.5 clk = ~clk;

   relay_channel_scan_sequencer #(.TICK_CYCLES_P(TICKS)) dut (
      .clk(clk), .rst(rst), .key_strobe(key_strobe), .key_code(key_code),
      .installed_chans(installed_chans), .relay_chan_q(relay_chan_q),
      .relay_close_q(relay_close_q), .pole_width_q(pole_width_q),
      .cur_chan_q(cur_chan_q), .run_lamp_q(run_lamp_q),
      .single_lamp_q(single_lamp_q), .cont_lamp_q(cont_lamp_q),
      .chan_lamp_q(chan_lamp_q), .error_lamp_q(error_lamp_q));

   scan_partner kp (
      .clk(clk), .key_strobe(key_strobe), .key_code(key_code),
      .relay_chan_q(relay_chan_q), .relay_close_q(relay_close_q));

   // Length of each closure in clocks
   always @(posedge clk)
   begin
      if (relay_close_q)
         run_len <= run_len + 1;
      else if (run_len != 0)
      begin
         last_len <= run_len;
         run_len <= 0;
      end
   end

   task automatic check(input logic [19:0] seen, input logic [19:0] exp);
      checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   task automatic seq(input logic [KEY_W-1:0] k [$]);
      foreach (k[i])
         kp.press(k[i]);
   endtask

   // Bounded wait for the relay (sel 0) or run lamp (sel 1) to reach v
   task automatic wait_lvl(input logic sel, input logic v);
      int n;
      n = 0;
      while ((sel ? run_lamp_q : relay_close_q) !== v && n < 3000)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 3000)
         check(1'b0, 1'b1);
   endtask

   task automatic end_test(input string name);
      $display("test %s done", name);
   endtask

   task automatic step_run(input logic [6:0] ch, input logic [6:0] nxt);
      kp.press(KEY_RUN);
      check({relay_close_q, run_lamp_q}, 2'b11);
      check(relay_chan_q, ch);
      wait_lvl(1'b0, 1'b0);
      @(posedge clk);
      #1;
      check(run_lamp_q, 1'b0);
      check(cur_chan_q, nxt);
      check(last_len >= DWELL && last_len <= DWELL + 2, 1'b1);
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Watchdog well beyond the expected run of about a thousand cycles
   initial
   begin
      #(25 * 30000);
      num_errors++;
      give_verdict();
   end

   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check({cur_chan_q, relay_close_q, run_lamp_q}, 9'h004);
      check(pole_width_q, POLES_RST);
      end_test("reset");
      // Pole widths, then a refused choice that keeps waiting
      foreach (pw[i])
      begin
         seq('{KEY_PROGRAM, 5'h06, 5'(pw[i]), KEY_ENTER});
         check(pole_width_q, pw[i]);
      end
      seq('{KEY_PROGRAM, 5'h06, 5'h03});
      check(error_lamp_q, 1'b1);
      seq('{5'h02, KEY_ENTER});
      check(pole_width_q, POLES_2);
      end_test("poles");
      // Channel 25 is not installed
      seq('{5'h02, 5'h05, KEY_FIRST});
      check(error_lamp_q, 1'b1);
      seq('{5'h00, 5'h03, KEY_FIRST, 5'h00, 5'h05, KEY_LAST});
      check(error_lamp_q, 1'b0);
      seq('{KEY_INTERVAL, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h09});
      kp.press(KEY_ENTER);
      check(error_lamp_q, 1'b1);
      seq('{KEY_INTERVAL, 5'h00, 5'h00, 5'h00, 5'h00, 5'h01, 5'h00});
      kp.press(KEY_ENTER);
      check(error_lamp_q, 1'b0);
      seq('{KEY_CHANNEL, KEY_RESET});
      check({chan_lamp_q, cur_chan_q}, 8'h83);
      end_test("entry");
      // Step mode wraps from the end channel
      step_run(7'h03, 7'h04);
      step_run(7'h04, 7'h05);
      step_run(7'h05, 7'h03);
      end_test("step");
      kp.press(KEY_SINGLE);
      check({single_lamp_q, cont_lamp_q}, 2'b10);
      kp.closed_q.delete();
      kp.press(KEY_RUN);
      wait_lvl(1'b1, 1'b0);
      @(negedge clk);
      check(kp.closed_q.size(), 3);
      foreach (kp.closed_q[i])
         check(kp.closed_q[i], 7'(3 + i));
      check({cur_chan_q, relay_close_q}, 8'h06);
      end_test("single");
      kp.press(KEY_CONT);
      check({single_lamp_q, cont_lamp_q}, 2'b01);
      kp.closed_q.delete();
      kp.press(KEY_RUN);
      for (int n = 0; n < 3000 && kp.closed_q.size() < 5; n++)
         @(negedge clk);
      check(kp.closed_q[3], 7'h03);
      kp.press(KEY_RUN);
      check({relay_close_q, run_lamp_q, relay_chan_q}, 9'h104);
      repeat (100) @(negedge clk);
      // Keep the relay bit inside the 20 bits that the compare sees
      check({relay_close_q, 19'(kp.closed_q.size())}, 20'h8_0005);
      kp.press(KEY_RUN);
      check({relay_close_q, run_lamp_q}, 2'b11);
      kp.press(KEY_RESET);
      check({relay_close_q, run_lamp_q, cur_chan_q}, 9'h003);
      check(kp.violations, 0);
      end_test("continuous");
      give_verdict();
   end
endmodule
`default_nettype wire
